// File: verilog/ssr_regs.sv
// Status register and input select register of a delta-sigma converter.
// Assumes requests arrive already decoded from register read and write commands, synchronous.
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_regs (
    // Clock and reset
    input  wire logic                  clock_in,
    input  wire logic                  reset_in,
    // Register command port
    input  wire ssr_pkg::ssr_req_s     req_in,
    output logic [7:0]                 rdata_out,
    output logic                       rvalid_out,
    // Analog monitor levels and enables from other registers
    input  wire ssr_pkg::ssr_monitor_s mon_in,
    input  wire logic                  not_ready_in,
    input  wire logic                  rail_monitor_enable_in,
    input  wire logic                  ref_monitor_enable_in,
    // Multiplexer selection
    output logic [3:0]                 positive_input_code_out,
    output logic [3:0]                 negative_input_code_out
);

    ////////////////////////////////////////////////////////////////////////////////
    logic       power_on_flag;
    logic       next_power_on_flag;
    logic [7:0] input_select;
    logic [7:0] next_input_select;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       rvalid;
    logic       next_rvalid;
    logic [7:0] status_view;

    function automatic logic hit(input ssr_pkg::ssr_req_s r, input logic [4:0] a);
        hit = (r.addr == a);
    endfunction

    // Rail and reference flags are gated by their monitor enables; the ready flag is not.
    always_comb begin
        status_view = 8'h00;
        status_view[`SSR_POR_BIT] = power_on_flag;
        status_view[`SSR_RDY_BIT] = not_ready_in;
        if (rail_monitor_enable_in) begin
            status_view[`SSR_POS_HIGH_BIT] = mon_in.pos_near_high;
            status_view[`SSR_POS_LOW_BIT]  = mon_in.pos_near_low;
            status_view[`SSR_NEG_HIGH_BIT] = mon_in.neg_near_high;
            status_view[`SSR_NEG_LOW_BIT]  = mon_in.neg_near_low;
        end
        if (ref_monitor_enable_in) begin
            status_view[`SSR_REF_THIRD_BIT] = mon_in.ref_below_third;
            status_view[`SSR_REF_FLOOR_BIT] = mon_in.ref_below_floor;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_power_on_flag = power_on_flag;
        next_input_select  = input_select;
        next_rdata         = rdata;
        next_rvalid        = 1'b0;
        // Only a write of zero clears the flag; writing one leaves it unchanged.
        if (req_in.wr && hit(req_in, `SSR_STATUS_ADDR) && !req_in.wdata[`SSR_POR_BIT]) begin
            next_power_on_flag = 1'b0;
        end
        if (req_in.wr && hit(req_in, `SSR_INPUT_SEL_ADDR)) begin
            next_input_select = req_in.wdata;
        end
        if (req_in.rd) begin
            next_rvalid = 1'b1;
            if (hit(req_in, `SSR_STATUS_ADDR)) begin
                next_rdata = status_view;
            end else if (hit(req_in, `SSR_INPUT_SEL_ADDR)) begin
                next_rdata = input_select;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            power_on_flag <= 1'b1;
            input_select  <= `SSR_INPUT_SEL_RESET;
            rdata         <= 8'h00;
            rvalid        <= 1'b0;
        end else begin
            power_on_flag <= next_power_on_flag;
            input_select  <= next_input_select;
            rdata         <= next_rdata;
            rvalid        <= next_rvalid;
        end
    end

    assign rdata_out  = rdata;
    assign rvalid_out = rvalid;
    assign positive_input_code_out = input_select[`SSR_POS_CODE_MSB:`SSR_POS_CODE_LSB];
    assign negative_input_code_out = input_select[`SSR_NEG_CODE_MSB:`SSR_NEG_CODE_LSB];

    ////////////////////////////////////////////////////////////////////////////////
    property p_por_clear;
        @(posedge clock_in) disable iff (reset_in)
        (req_in.wr && req_in.addr == `SSR_STATUS_ADDR && !req_in.wdata[7]) |=> !power_on_flag;
    endproperty
    a_por_clear: assert property (p_por_clear) else $error("power-on flag not cleared");

    property p_por_hold;
        @(posedge clock_in) disable iff (reset_in)
        !power_on_flag |=> !power_on_flag;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("power-on flag set again");

    property p_rdy_read;
        @(posedge clock_in) disable iff (reset_in)
        (req_in.rd && req_in.addr == `SSR_STATUS_ADDR) |=> rdata_out[6] == $past(not_ready_in);
    endproperty
    a_rdy_read: assert property (p_rdy_read) else $error("ready bit wrong");

    property p_rail_gate;
        @(posedge clock_in) disable iff (reset_in)
        (req_in.rd && req_in.addr == `SSR_STATUS_ADDR && !rail_monitor_enable_in)
            |=> rdata_out[5:2] == 4'h0;
    endproperty
    a_rail_gate: assert property (p_rail_gate) else $error("rail flag while disabled");

    property p_rail_pass;
        @(posedge clock_in) disable iff (reset_in)
        (req_in.rd && req_in.addr == `SSR_STATUS_ADDR && rail_monitor_enable_in)
            |=> rdata_out[5:2] == {$past(mon_in.pos_near_high), $past(mon_in.pos_near_low),
                                   $past(mon_in.neg_near_high), $past(mon_in.neg_near_low)};
    endproperty
    a_rail_pass: assert property (p_rail_pass) else $error("rail flag lost");

    property p_ref_gate;
        @(posedge clock_in) disable iff (reset_in)
        (req_in.rd && req_in.addr == `SSR_STATUS_ADDR)
            |=> rdata_out[1:0] == ($past(ref_monitor_enable_in)
                ? {$past(mon_in.ref_below_third), $past(mon_in.ref_below_floor)} : 2'h0);
    endproperty
    a_ref_gate: assert property (p_ref_gate) else $error("ref flag wrong");

    property p_mux_write;
        @(posedge clock_in) disable iff (reset_in)
        (req_in.wr && req_in.addr == `SSR_INPUT_SEL_ADDR)
            |=> {positive_input_code_out, negative_input_code_out} == $past(req_in.wdata);
    endproperty
    a_mux_write: assert property (p_mux_write) else $error("select lost");

    property p_mux_hold;
        @(posedge clock_in) disable iff (reset_in)
        !(req_in.wr && req_in.addr == `SSR_INPUT_SEL_ADDR) |=> $stable(input_select);
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("input select changed");

    property p_por_keep;
        @(posedge clock_in) disable iff (reset_in)
        (power_on_flag && !(req_in.wr && req_in.addr == `SSR_STATUS_ADDR && !req_in.wdata[7]))
            |=> power_on_flag;
    endproperty
    a_por_keep: assert property (p_por_keep) else $error("power-on flag lost");

    property p_read_answer;
        @(posedge clock_in) disable iff (reset_in)
        req_in.rd |=> rvalid_out;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    property p_stray_answer;
        @(posedge clock_in) disable iff (reset_in)
        !req_in.rd |=> !rvalid_out;
    endproperty
    a_stray_answer: assert property (p_stray_answer) else $error("stray read answer");

    property p_unmapped_read;
        @(posedge clock_in) disable iff (reset_in)
        (req_in.rd && req_in.addr != `SSR_STATUS_ADDR && req_in.addr != `SSR_INPUT_SEL_ADDR)
            |=> rdata_out == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped data");

    property p_mux_read;
        @(posedge clock_in) disable iff (reset_in)
        (req_in.rd && req_in.addr == `SSR_INPUT_SEL_ADDR)
            |=> rdata_out == {$past(positive_input_code_out), $past(negative_input_code_out)};
    endproperty
    a_mux_read: assert property (p_mux_read) else $error("input select read wrong");

    // Checked at the first edge after any release, before the first request can land.
    property p_reset_defaults;
        @(posedge clock_in)
        $fell(reset_in) |-> power_on_flag && !rvalid_out && rdata_out == 8'h00
            && input_select == `SSR_INPUT_SEL_RESET;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("defaults wrong");

    c_por_clear: cover property (@(posedge clock_in) disable iff (reset_in)
        $fell(power_on_flag));
    c_mux_write: cover property (@(posedge clock_in) disable iff (reset_in)
        req_in.wr && req_in.addr == `SSR_INPUT_SEL_ADDR);
    c_rail_seen: cover property (@(posedge clock_in) disable iff (reset_in)
        rvalid_out && rdata_out[5]);
    c_ref_seen: cover property (@(posedge clock_in) disable iff (reset_in)
        rvalid_out && rdata_out[1:0] != 2'h0);
    c_por_kept: cover property (@(posedge clock_in) disable iff (reset_in)
        req_in.wr && req_in.addr == `SSR_STATUS_ADDR && req_in.wdata[7]);

endmodule

// File: verilog/ssr_defines.svh
// Offsets, field positions, reset values and figures of the status and input select registers.
// Assumes inclusion by bare name from the package and the register bank module.
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

`define SSR_ADDR_W            5
`define SSR_STATUS_ADDR       5'h01
`define SSR_INPUT_SEL_ADDR    5'h02
`define SSR_STATUS_RESET      8'h80
`define SSR_INPUT_SEL_RESET   8'h01
`define SSR_POR_BIT           7
`define SSR_RDY_BIT           6
`define SSR_POS_HIGH_BIT      5
`define SSR_POS_LOW_BIT       4
`define SSR_NEG_HIGH_BIT      3
`define SSR_NEG_LOW_BIT       2
`define SSR_REF_THIRD_BIT     1
`define SSR_REF_FLOOR_BIT     0
`define SSR_POS_CODE_MSB      7
`define SSR_POS_CODE_LSB      4
`define SSR_NEG_CODE_MSB      3
`define SSR_NEG_CODE_LSB      0
`define SSR_MAX_INPUT_CODE    4'hb
`define SSR_RAIL_MARGIN_MV    150
`define SSR_REF_FLOOR_MV      300

`endif

// File: verilog/ssr_pkg.sv
// Types shared by the status and input select register bank.
// Assumes the defines header is on the include path.
`include "ssr_defines.svh"

package ssr_pkg;

    // Raw comparator levels from the analog monitors.
    typedef struct packed {
        logic pos_near_high;
        logic pos_near_low;
        logic neg_near_high;
        logic neg_near_low;
        logic ref_below_third;
        logic ref_below_floor;
    } ssr_monitor_s;

    // Register access request from the serial command decoder.
    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`SSR_ADDR_W-1:0]   addr;
        logic [7:0]               wdata;
    } ssr_req_s;

endpackage

// File: dv/ssr_host.sv
// Host model that issues register read and write commands to the register bank.
// Assumes the bank's clock; requests change only just after rising edges.
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_host (
    // Clock
    input  wire logic         clock_in,
    // Register command port
    output ssr_pkg::ssr_req_s req_out
);
    initial req_out = '0;

    // Presents one command until the next call; only register commands reach the bank.
    task automatic issue(input logic wr, input logic rd, input logic [`SSR_ADDR_W-1:0] addr,
                         input logic [7:0] wdata);
        @(posedge clock_in);
        req_out <= '{wr: wr, rd: rd, addr: addr, wdata: wdata};
    endtask

    // Releases the port; idle fields keep changing so stale values are never trusted.
    task automatic idle();
        @(posedge clock_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~req_out.addr, wdata: ~req_out.wdata};
    endtask
endmodule

// File: dv/ssr_regs_tb.sv
// Self-checking bench for the status and input select register bank.
// Assumes the host model drives the command port and expected reads queue in order.
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_regs_tb;
    logic                  clock_in = 1'b0;
    logic                  reset_in = 1'b1;
    ssr_pkg::ssr_req_s     req;
    ssr_pkg::ssr_monitor_s mon = '0;
    logic                  not_ready = 1'b0, rail_en = 1'b0, ref_en = 1'b0, por = 1'b1;
    logic                  rvalid;
    logic [7:0]            rdata, exp_q[$];
    logic [3:0]            pos_code, neg_code;
    int                    bad_count = 0, compares = 0;
    // Twelve inputs here; a six-channel part would set six.
    localparam int         input_count = 12;

    always #2.5 clock_in = ~clock_in;

    ssr_host i_host (.clock_in(clock_in), .req_out(req));
    ssr_regs i_dut (.clock_in(clock_in), .reset_in(reset_in), .req_in(req), .rdata_out(rdata),
        .rvalid_out(rvalid), .mon_in(mon), .not_ready_in(not_ready),
        .rail_monitor_enable_in(rail_en), .ref_monitor_enable_in(ref_en),
        .positive_input_code_out(pos_code), .negative_input_code_out(neg_code));

    task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic rd(input logic [4:0] addr, input logic [7:0] exp);
        i_host.issue(1'b0, 1'b1, addr, 8'($urandom));
        exp_q.push_back(exp);
    endtask

    // Expected status built from the live, gated monitor levels.
    task automatic rd_status();
        i_host.issue(1'b0, 1'b1, `SSR_STATUS_ADDR, 8'($urandom));
        exp_q.push_back({por, not_ready, rail_en ? mon[5:2] : 4'h0, ref_en ? mon[1:0] : 2'h0});
    endtask

    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        i_host.issue(1'b1, 1'b0, addr, data);
        if (addr == `SSR_STATUS_ADDR && !data[7])
            por = 1'b0;
    endtask

    task automatic drain();
        for (int k = 0; k < 10 && exp_q.size() > 0; k++)
            @(posedge clock_in);
        if (exp_q.size() > 0) begin
            bad_count++;
            wrap_up();
        end
    endtask

    always @(posedge clock_in) begin
        if (rvalid === 1'b1)
            compare_byte(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end

    initial begin
        logic [7:0] v;
        v = 8'($urandom(11163));
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        mon <= 6'($urandom);
        rd(`SSR_STATUS_ADDR, 8'h80);
        rd(`SSR_INPUT_SEL_ADDR, 8'h01);
        #1;
        compare_byte({pos_code, neg_code}, 8'h01);
        for (int i = 0; i < 32; i++) begin
            i_host.idle();
            {mon, not_ready, rail_en, ref_en} <= 9'($urandom);
            rd_status();
        end
        wr(`SSR_STATUS_ADDR, 8'h80);
        rd_status();
        wr(`SSR_STATUS_ADDR, 8'h7f);
        rd_status();
        for (int i = 0; i < 16; i++) begin
            // Only mapped input codes are written; reserved codes stay unused.
            v = {4'(i % input_count), 4'($urandom % input_count)};
            wr(`SSR_INPUT_SEL_ADDR, v);
            rd(`SSR_INPUT_SEL_ADDR, v);
            i_host.idle();
            #1;
            compare_byte({pos_code, neg_code}, v);
        end
        wr(5'h03, 8'hff);
        rd(5'h03, 8'h00);
        rd(`SSR_INPUT_SEL_ADDR, v);
        i_host.idle();
        drain();
        reset_in <= 1'b1;
        {not_ready, rail_en, ref_en} <= 3'h0;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        por = 1'b1;
        rd(`SSR_STATUS_ADDR, 8'h80);
        rd(`SSR_INPUT_SEL_ADDR, 8'h01);
        i_host.idle();
        drain();
        wrap_up();
    end
endmodule
